// ---- rtl/pwo_duty_cmp.sv ----
// duty clamp, duty to compare conversion and dead-time correction
`timescale 1ns/100ps
module pwo_duty_cmp
	import pwo_pkg::*;
#(
	parameter int DW = 19,
	parameter int CW = 16
)
(
	input wire logic signed [DW-1:0] duty_in,
	input wire logic signed [DW-1:0] duty_max_in,
	input wire logic signed [DW-1:0] duty_min_in,
	input wire logic [CW-1:0] period_in,
	input wire logic [CW-1:0] dt_cyc_in,
	input wire logic cur_pos_in,
	output logic signed [DW-1:0] duty_clamped_out,
	output logic [CW-1:0] cmp_out
);
	logic [DW-1:0] on_frac;
	logic [DW+CW-1:0] prod;
	logic [CW:0] raw;
	logic [CW+1:0] adj;

	always_comb
	begin
		if (duty_in > duty_max_in)
			duty_clamped_out = duty_max_in; // see [RULE1]
		else if (duty_in < duty_min_in)
			duty_clamped_out = duty_min_in; // see [RULE1]
		else
			duty_clamped_out = duty_in;
		// -1 is off all period, +1 on all period
		on_frac = DW'(duty_clamped_out + DW'(PWO_DUTY_ONE)); // see [RULE2]
		prod = (DW+CW)'(on_frac) * (DW+CW)'(period_in);
		raw = prod[PWO_Q_FRAC+1 +: CW+1]; // see [RULE20]
		if (dt_cyc_in == '0)
			adj = (CW+2)'(raw); // see [RULE14]
		else if (cur_pos_in)
			adj = (CW+2)'(raw) + (CW+2)'(dt_cyc_in); // see [RULE14]
		else if ((CW+2)'(raw) > (CW+2)'(dt_cyc_in))
			adj = (CW+2)'(raw) - (CW+2)'(dt_cyc_in);
		else
			adj = '0;
		// correction may not push past a full period
		if (adj > (CW+2)'(period_in))
			cmp_out = period_in;
		else
			cmp_out = adj[CW-1:0];
	end
endmodule

// ---- rtl/pwo_gate_run.sv ----
// gate output stage with run and grid fault supervision
//
// Contract
// [RULE1] commanded duty is clamped between configured minimum and maximum
// [RULE2] duty is signed: -1 off, 0 half, +1 fully on, linear
// [RULE3] channel select 0: modulate A, B is complement of A
// [RULE4] channel select 1: modulate B, A is complement of B
// [RULE5] gates active high, all held low whenever converter is off
// [RULE6] a switch is closed by driving its gate high, opened low
// [RULE7] grid sense select: 0 line-to-neutral, 1 line-to-line
// [RULE8] grid voltage or frequency fault while on forces fault state, outputs off
// [RULE9] auto recovery clears grid faults after reconnect delay, returns on
// [RULE10] without auto recovery grid faults latch until a fault reset
// [RULE11] current mode, power factor unused: both targets from own setpoints
// [RULE12] current mode, power factor used: reactive derived from real and pf
// [RULE13] voltage mode: regulator output is real target, reactive from pf
// [RULE14] dead-time correction sized by programmed dead time, zero disables
// [RULE15] modulation type: 0 space vector, 1 sinusoidal
// [RULE16] hardware run control: on while isolated run input high
// [RULE17] hardware run control: isolated reset rising edge clears latched faults
// [RULE18] hardware run control: software run command ignored
// [RULE19] software run control: isolated run and reset inputs ignored
// [RULE20] compare equals half of one plus duty times carrier period
`timescale 1ns/100ps
module pwo_gate_run
	import pwo_pkg::*;
#(
	parameter int CW = 16,
	parameter int PWM_PERIOD_CYC = PWO_PWM_PERIOD_CYC,
	parameter int RECONNECT_CYC = PWO_RECONNECT_CYC
)
(
	input wire logic ref_clk_in,
	input wire logic sys_rst_in,
	input wire logic signed [17:0] duty_max_in,
	input wire logic signed [17:0] duty_min_in,
	input wire logic chan_sel_in,
	input wire logic sense_sel_in,
	input wire logic auto_recover_in,
	input wire logic pf_use_in,
	input wire logic mod_type_in,
	input wire logic hw_run_en_in,
	input wire logic [15:0] dead_time_ns_in,
	input wire logic ctrl_mode_in,
	input wire logic signed [17:0] id_set_in,
	input wire logic signed [17:0] iq_set_in,
	input wire logic signed [17:0] pf_set_in,
	input wire logic signed [17:0] vreg_out_in,
	input wire logic [PWO_PHASES*18-1:0] phase_ref_in,
	input wire logic [PWO_PHASES-1:0] cur_pos_in,
	input wire logic run_cmd_in,
	input wire logic fault_reset_cmd_in,
	input wire logic iso_run_in,
	input wire logic iso_fault_reset_in,
	input wire logic [15:0] grid_v_in,
	input wire logic [15:0] grid_v_min_in,
	input wire logic [15:0] grid_v_max_in,
	input wire logic [15:0] grid_freq_in,
	input wire logic [15:0] grid_f_min_in,
	input wire logic [15:0] grid_f_max_in,
	input wire logic other_fault_in,
	output logic [PWO_PHASES-1:0] gate_a_out,
	output logic [PWO_PHASES-1:0] gate_b_out,
	output logic [1:0] state_out,
	output logic grid_v_fault_out,
	output logic grid_f_fault_out,
	output logic other_fault_out,
	output logic signed [17:0] id_tgt_out,
	output logic signed [17:0] iq_tgt_out,
	output logic [15:0] grid_v_ln_out
);
	if (PWM_PERIOD_CYC < 2 || PWM_PERIOD_CYC >= 2 ** CW)
	begin : g_chk_period
		$error("carrier period does not fit the counter");
	end
	if (RECONNECT_CYC < 1 || RECONNECT_CYC >= 2 ** 30)
	begin : g_chk_recon
		$error("reconnect delay out of range");
	end

	localparam logic [CW-1:0] PERIOD = CW'(PWM_PERIOD_CYC);
	localparam logic [29:0] RECON_LAST = 30'(RECONNECT_CYC - 1);

	pwo_state_t state;
	pwo_state_t next_state;
	logic [1:0] iso_sync;
	logic iso_rst_d;
	logic run_eff;
	logic iso_rise;
	logic fault_rst_eff;
	logic [15:0] grid_v_ln;
	logic v_bad;
	logic f_bad;
	logic grid_bad;
	logic grid_v_fault;
	logic grid_f_fault;
	logic other_fault;
	logic [29:0] recon_cnt;
	logic recover_done;
	logic [CW-1:0] carrier;
	logic [CW-1:0] dt_cyc;
	logic signed [18:0] duty [PWO_PHASES];
	logic signed [18:0] duty_clamped [PWO_PHASES];
	logic [CW-1:0] cmp_next [PWO_PHASES];
	logic [CW-1:0] cmp [PWO_PHASES];
	logic [PWO_PHASES-1:0] pwm_on;
	logic [PWO_PHASES-1:0] gate_a;
	logic [PWO_PHASES-1:0] gate_b;
	logic signed [17:0] id_tgt;
	logic signed [17:0] iq_tgt;

	// ************************************************************
	// isolated pins and run source selection
	// ************************************************************
	pwo_sync #(.W(2)) u_iso_sync (
		.ref_clk_in(ref_clk_in),
		.sys_rst_in(sys_rst_in),
		.async_in({iso_fault_reset_in, iso_run_in}),
		.sync_out(iso_sync)
	);

	always_ff @(posedge ref_clk_in)
	begin
		if (sys_rst_in)
			iso_rst_d <= 1'b0;
		else
			iso_rst_d <= iso_sync[1];
	end

	assign iso_rise = iso_sync[1] & ~iso_rst_d;
	// an open pin reads low, so the converter stays off
	assign run_eff = hw_run_en_in ? iso_sync[0] : run_cmd_in; // see [RULE16] see [RULE18] see [RULE19]
	assign fault_rst_eff = hw_run_en_in ? iso_rise : fault_reset_cmd_in; // see [RULE17] see [RULE19]

	// ************************************************************
	// grid supervision
	// ************************************************************
	always_ff @(posedge ref_clk_in)
	begin
		if (sys_rst_in)
			grid_v_ln <= 16'h0000;
		else if (sense_sel_in == PWO_SENSE_LL)
			grid_v_ln <= 16'((33'(grid_v_in) * 33'(PWO_INV_SQRT3_Q16)) >> PWO_Q_FRAC); // see [RULE7]
		else
			grid_v_ln <= grid_v_in; // see [RULE7]
	end

	assign v_bad = (grid_v_ln < grid_v_min_in) || (grid_v_ln > grid_v_max_in);
	assign f_bad = (grid_freq_in < grid_f_min_in) || (grid_freq_in > grid_f_max_in);
	assign grid_bad = v_bad | f_bad;

	// a still-present condition re-asserts its flag over a clear
	always_ff @(posedge ref_clk_in)
	begin
		if (sys_rst_in)
		begin
			grid_v_fault <= 1'b0;
			grid_f_fault <= 1'b0;
		end
		else
		begin
			grid_v_fault <= (grid_v_fault & ~(fault_rst_eff | recover_done))
				| (v_bad & (state == PWO_ST_ON | grid_v_fault)); // see [RULE8] see [RULE10]
			grid_f_fault <= (grid_f_fault & ~(fault_rst_eff | recover_done))
				| (f_bad & (state == PWO_ST_ON | grid_f_fault)); // see [RULE8] see [RULE10]
		end
	end

	always_ff @(posedge ref_clk_in)
	begin
		if (sys_rst_in)
			other_fault <= 1'b0;
		else
			other_fault <= (other_fault & ~fault_rst_eff) | other_fault_in;
	end

	// ************************************************************
	// automatic grid reconnect timer
	// ************************************************************
	always_ff @(posedge ref_clk_in)
	begin
		if (sys_rst_in)
			recon_cnt <= 30'h00000000;
		else if (state == PWO_ST_FAULT && auto_recover_in && !grid_bad && !other_fault
			&& run_eff && (grid_v_fault | grid_f_fault) && !recover_done)
			recon_cnt <= recon_cnt + 30'h00000001; // see [RULE9]
		else
			recon_cnt <= 30'h00000000;
	end

	assign recover_done = (recon_cnt == RECON_LAST); // see [RULE9]

	// ************************************************************
	// run state
	// ************************************************************
	always_comb
	begin
		next_state = state;
		case (state)
			PWO_ST_OFF:
				if (grid_v_fault | grid_f_fault | other_fault)
					next_state = PWO_ST_FAULT;
				else if (run_eff)
					next_state = PWO_ST_ON;
			PWO_ST_ON:
				if (grid_bad | other_fault_in)
					next_state = PWO_ST_FAULT; // see [RULE8]
				else if (!run_eff)
					next_state = PWO_ST_OFF;
			PWO_ST_FAULT:
				if (!(grid_v_fault | grid_f_fault | other_fault))
					next_state = (run_eff && auto_recover_in) ? PWO_ST_ON : PWO_ST_OFF; // see [RULE9]
			default:
				next_state = PWO_ST_OFF;
		endcase
	end

	always_ff @(posedge ref_clk_in)
	begin
		if (sys_rst_in)
			state <= PWO_ST_OFF;
		else
			state <= next_state;
	end

	// ************************************************************
	// current targets
	// ************************************************************
	function automatic logic signed [17:0] pwo_react(input logic signed [17:0] re_cur,
		input logic signed [17:0] pf);
		logic [17:0] pf_abs;
		logic [15:0] ratio;
		logic signed [35:0] prod;
		pf_abs = pf[17] ? 18'(-pf) : 18'(pf);
		ratio = (pf_abs >= 18'(PWO_DUTY_ONE)) ? 16'h0000 : PWO_TAN_LUT[pf_abs[15:12]];
		prod = (36'(re_cur) * $signed({20'h00000, ratio})) >>> PWO_TAN_Q;
		if (pf[17])
			prod = -prod;
		if (prod > 36'sh00001ffff)
			return 18'sh1ffff;
		else if (prod < -36'sh000020000)
			return 18'sh20000;
		else
			return prod[17:0];
	endfunction

	always_ff @(posedge ref_clk_in)
	begin
		if (sys_rst_in)
		begin
			id_tgt <= PWO_TGT_RST;
			iq_tgt <= PWO_TGT_RST;
		end
		else if (ctrl_mode_in == PWO_MODE_VOLTAGE)
		begin
			id_tgt <= vreg_out_in; // see [RULE13]
			iq_tgt <= pwo_react(vreg_out_in, pf_set_in); // see [RULE13]
		end
		else if (pf_use_in)
		begin
			id_tgt <= id_set_in;
			iq_tgt <= pwo_react(id_set_in, pf_set_in); // see [RULE12]
		end
		else
		begin
			id_tgt <= id_set_in; // see [RULE11]
			iq_tgt <= iq_set_in; // see [RULE11]
		end
	end

	// ************************************************************
	// modulation and carrier
	// ************************************************************
	always_comb
	begin
		logic signed [17:0] mx;
		logic signed [17:0] mn;
		logic signed [18:0] offs;
		mx = $signed(phase_ref_in[17:0]);
		mn = mx;
		offs = '0;
		for (int p = 1; p < PWO_PHASES; p++)
		begin
			if ($signed(phase_ref_in[p*18 +: 18]) > mx)
				mx = $signed(phase_ref_in[p*18 +: 18]);
			if ($signed(phase_ref_in[p*18 +: 18]) < mn)
				mn = $signed(phase_ref_in[p*18 +: 18]);
		end
		// min-max zero-sequence injection is the space-vector equivalent
		offs = -((19'(mx) + 19'(mn)) >>> 1);
		for (int p = 0; p < PWO_PHASES; p++)
		begin
			if (mod_type_in == PWO_MOD_SPACE_VECTOR)
				duty[p] = 19'($signed(phase_ref_in[p*18 +: 18])) + offs; // see [RULE15]
			else
				duty[p] = 19'($signed(phase_ref_in[p*18 +: 18])); // see [RULE15]
		end
	end

	always_ff @(posedge ref_clk_in)
	begin
		if (sys_rst_in)
			dt_cyc <= '0;
		else
			dt_cyc <= CW'(32'(dead_time_ns_in) * PWO_CLK_MHZ / PWO_NS_PER_US); // see [RULE14]
	end

	always_ff @(posedge ref_clk_in)
	begin
		if (sys_rst_in || carrier == PERIOD - CW'(1))
			carrier <= '0;
		else
			carrier <= carrier + CW'(1);
	end

	// ************************************************************
	// per-phase compare and gate drive
	// ************************************************************
	for (genvar i = 0; i < PWO_PHASES; i++)
	begin : g_phase
		pwo_duty_cmp #(.DW(19), .CW(CW)) u_cmp (
			.duty_in(duty[i]),
			.duty_max_in(19'(duty_max_in)),
			.duty_min_in(19'(duty_min_in)),
			.period_in(PERIOD),
			.dt_cyc_in(dt_cyc),
			.cur_pos_in(cur_pos_in[i]),
			.duty_clamped_out(duty_clamped[i]),
			.cmp_out(cmp_next[i])
		);

		// new compare only at carrier wrap, so no runt pulses
		always_ff @(posedge ref_clk_in)
		begin
			if (sys_rst_in)
				cmp[i] <= '0;
			else if (carrier == PERIOD - CW'(1))
				cmp[i] <= cmp_next[i];
		end

		assign pwm_on[i] = carrier < cmp[i];

		always_ff @(posedge ref_clk_in)
		begin
			if (sys_rst_in || state != PWO_ST_ON)
			begin
				gate_a[i] <= 1'b0; // see [RULE5]
				gate_b[i] <= 1'b0; // see [RULE5]
			end
			else if (chan_sel_in == PWO_CHAN_A_MOD)
			begin
				gate_a[i] <= pwm_on[i]; // see [RULE3] see [RULE6]
				gate_b[i] <= ~pwm_on[i]; // see [RULE3]
			end
			else
			begin
				gate_b[i] <= pwm_on[i]; // see [RULE4] see [RULE6]
				gate_a[i] <= ~pwm_on[i]; // see [RULE4]
			end
		end
	end

	assign gate_a_out = gate_a;
	assign gate_b_out = gate_b;
	assign state_out = state;
	assign grid_v_fault_out = grid_v_fault;
	assign grid_f_fault_out = grid_f_fault;
	assign other_fault_out = other_fault;
	assign id_tgt_out = id_tgt;
	assign iq_tgt_out = iq_tgt;
	assign grid_v_ln_out = grid_v_ln;

	// ************************************************************
	// assertions
	// ************************************************************
	default clocking @(posedge ref_clk_in); endclocking
	default disable iff (sys_rst_in);

	a_duty_in_range: assert property ((duty_clamped[0] <= 19'(duty_max_in) || duty_max_in < duty_min_in)
		&& (duty_clamped[0] >= 19'(duty_min_in) || duty_max_in < duty_min_in)) // see [RULE1]
		else $error("clamped duty outside configured limits");
	a_cmp_in_period: assert property (cmp[1] <= PERIOD) // see [RULE20]
		else $error("compare beyond carrier period");
	a_off_gates_low: assert property (state != PWO_ST_ON |=> gate_a_out == '0 && gate_b_out == '0) // see [RULE5]
		else $error("gate driven while not on");
	a_chan_a_zero: assert property (state == PWO_ST_ON && chan_sel_in == PWO_CHAN_A_MOD && cmp[0] == '0
		|=> !gate_a_out[0] && gate_b_out[0]) // see [RULE3]
		else $error("channel a not modulated");
	a_chan_b_zero: assert property (state == PWO_ST_ON && chan_sel_in == PWO_CHAN_B_MOD && cmp[0] == '0
		|=> !gate_b_out[0] && gate_a_out[0]) // see [RULE4]
		else $error("channel b not modulated");
	a_grid_trip: assert property (state == PWO_ST_ON && grid_bad |=> state == PWO_ST_FAULT ##1 gate_a_out == '0) // see [RULE8]
		else $error("grid fault did not trip");
	a_latch_hold: assert property (state == PWO_ST_FAULT && grid_v_fault && !auto_recover_in && !fault_rst_eff
		|=> state == PWO_ST_FAULT && grid_v_fault_out) // see [RULE10]
		else $error("grid fault released without reset");
	a_recover_clear: assert property (recover_done |=> !grid_v_fault_out && !grid_f_fault_out) // see [RULE9]
		else $error("grid flags not cleared after reconnect delay");
	a_pf_unused: assert property (ctrl_mode_in == PWO_MODE_CURRENT && !pf_use_in
		|=> iq_tgt_out == $past(iq_set_in)) // see [RULE11]
		else $error("reactive target not from setpoint");
	a_vmode_real: assert property (ctrl_mode_in == PWO_MODE_VOLTAGE |=> id_tgt_out == $past(vreg_out_in)) // see [RULE13]
		else $error("real target not from regulator");
	a_hw_run_gate: assert property (hw_run_en_in && state == PWO_ST_OFF && !iso_sync[0]
		|=> state != PWO_ST_ON) // see [RULE16]
		else $error("turned on with run pin low");
	a_sw_pins_ign: assert property (!hw_run_en_in && state == PWO_ST_ON && run_cmd_in && !grid_bad
		&& !other_fault_in |=> state == PWO_ST_ON) // see [RULE19]
		else $error("pin affected software run control");
	a_pin_reset: assert property (hw_run_en_in && iso_rise && !other_fault_in |=> !other_fault_out) // see [RULE17]
		else $error("reset pin edge did not clear fault");

	c_run_on: cover property (state == PWO_ST_OFF ##1 state == PWO_ST_ON);
	c_grid_trip: cover property (state == PWO_ST_ON ##1 state == PWO_ST_FAULT);
	c_auto_back: cover property (recover_done ##[1:3] state == PWO_ST_ON);
	c_pin_reset: cover property (hw_run_en_in && iso_rise && state == PWO_ST_FAULT);
endmodule

// ---- rtl/pwo_pkg.sv ----
// constants and types shared by the gate output and run control block
package pwo_pkg;

	// ************************************************************
	// widths and fixed-point encodings
	// ************************************************************
	localparam int PWO_DW = 18;
	localparam int PWO_PHASES = 3;
	localparam int PWO_Q_FRAC = 16;
	localparam logic signed [17:0] PWO_DUTY_ONE = 18'sh10000;
	localparam logic signed [17:0] PWO_DUTY_NEG_ONE = 18'sh30000;
	localparam logic [16:0] PWO_INV_SQRT3_Q16 = 17'h093cd;
	localparam int PWO_TAN_Q = 12;

	// ************************************************************
	// timing
	// ************************************************************
	localparam int PWO_CLK_MHZ = 200;
	localparam int PWO_PWM_FREQ_HZ = 10000;
	localparam int PWO_PWM_PERIOD_CYC = PWO_CLK_MHZ * 1000000 / PWO_PWM_FREQ_HZ;
	localparam int PWO_RECONNECT_US = 1000;
	localparam int PWO_RECONNECT_CYC = PWO_RECONNECT_US * PWO_CLK_MHZ;
	localparam int PWO_NS_PER_US = 1000;

	// ************************************************************
	// setting encodings
	// ************************************************************
	localparam logic PWO_CHAN_A_MOD = 1'b0;
	localparam logic PWO_CHAN_B_MOD = 1'b1;
	localparam logic PWO_SENSE_LN = 1'b0;
	localparam logic PWO_SENSE_LL = 1'b1;
	localparam logic PWO_MOD_SPACE_VECTOR = 1'b0;
	localparam logic PWO_MOD_SINE = 1'b1;
	localparam logic PWO_MODE_CURRENT = 1'b0;
	localparam logic PWO_MODE_VOLTAGE = 1'b1;

	// ************************************************************
	// reset values
	// ************************************************************
	localparam logic [1:0] PWO_SYNC_RST = 2'h0;
	localparam logic [2:0] PWO_GATE_RST = 3'h0;
	localparam logic signed [17:0] PWO_TGT_RST = 18'sh00000;

	// reactive/real ratio per power-factor sixteenth, Q12, saturated
	localparam logic [15:0] PWO_TAN_LUT [16] = '{
		16'hffff, 16'ha9ec, 16'h6524, 16'h475f,
		16'h3698, 16'h2bb5, 16'h23fd, 16'h1e27,
		16'h1984, 16'h15af, 16'h1266, 16'h0f7a,
		16'h0cc9, 16'h0a2e, 16'h0777, 16'h0419
	};

	typedef enum logic [1:0] {PWO_ST_OFF, PWO_ST_ON, PWO_ST_FAULT} pwo_state_t;

endpackage

// ---- rtl/pwo_sync.sv ----
// two-flop synchroniser for pin inputs
`timescale 1ns/100ps
module pwo_sync
	import pwo_pkg::*;
#(
	parameter int W = 2
)
(
	input wire logic ref_clk_in,
	input wire logic sys_rst_in,
	input wire logic [W-1:0] async_in,
	output logic [W-1:0] sync_out
);
	logic [W-1:0] meta;
	logic [W-1:0] stable;

	always_ff @(posedge ref_clk_in)
	begin
		if (sys_rst_in)
		begin
			meta <= '0;
			stable <= '0;
		end
		else
		begin
			meta <= async_in;
			stable <= meta;
		end
	end

	assign sync_out = stable;
endmodule

// ---- test/pwo_gate_drv_model.sv ----
// behavioural gate driver pair for three half bridges, counts switch on-time
`timescale 1ns/100ps
module pwo_gate_drv_model
(
	input wire logic clk_in,
	input wire logic clr_in,
	input wire logic [2:0] gate_a_in,
	input wire logic [2:0] gate_b_in,
	output logic [7:0] top_cnt_out [3],
	output logic [7:0] bot_cnt_out [3],
	output logic [7:0] shoot_cnt_out
);
	// a high gate closes its switch; both closed in one leg shorts the link
	always_ff @(posedge clk_in)
	begin
		for (int p = 0; p < 3; p++)
		begin
			top_cnt_out[p] <= clr_in ? 8'h00 : top_cnt_out[p] + {7'h00, gate_a_in[p] === 1'b1};
			bot_cnt_out[p] <= clr_in ? 8'h00 : bot_cnt_out[p] + {7'h00, gate_b_in[p] === 1'b1};
		end
		shoot_cnt_out <= clr_in ? 8'h00 : shoot_cnt_out + {7'h00, |(gate_a_in & gate_b_in) !== 1'b0};
	end
endmodule

// ---- test/testbench.sv ----
// self-checking bench for the gate output and run control block
`timescale 1ns/100ps
module testbench;
	import pwo_pkg::*;
	// ********
	// stimulus and observation
	// ********
	logic ref_clk_in = 1'b0;
	logic sys_rst_in = 1'b1;
	logic signed [17:0] duty_max_in = 18'h0f333, duty_min_in = 18'h30ccd;
	logic chan_sel_in = 1'b0, sense_sel_in = 1'b0, auto_recover_in = 1'b0, pf_use_in = 1'b0;
	logic mod_type_in = 1'b1, hw_run_en_in = 1'b0, ctrl_mode_in = 1'b0, run_cmd_in = 1'b0;
	logic fault_reset_cmd_in = 1'b0, iso_run_in = 1'b0, iso_fault_reset_in = 1'b0, other_fault_in = 1'b0;
	logic [15:0] dead_time_ns_in = 16'h0000;
	logic signed [17:0] id_set_in = 18'h04000, iq_set_in = 18'h02000, pf_set_in = 18'h10000, vreg_out_in = 18'h03000;
	logic [53:0] phase_ref_in = 54'h0;
	logic [2:0] cur_pos_in = 3'h0;
	logic [15:0] grid_v_in = 16'h5000, grid_v_min_in = 16'h1000, grid_v_max_in = 16'h9000;
	logic [15:0] grid_freq_in = 16'h0100, grid_f_min_in = 16'h0080, grid_f_max_in = 16'h0200;
	logic [2:0] gate_a_out, gate_b_out;
	logic [1:0] state_out;
	logic grid_v_fault_out, grid_f_fault_out, other_fault_out;
	logic signed [17:0] id_tgt_out, iq_tgt_out;
	logic [15:0] grid_v_ln_out;
	logic clr = 1'b1;
	logic [7:0] top_cnt [3];
	logic [7:0] bot_cnt [3];
	logic [7:0] shoot_cnt;
	int n_errors = 0;
	int check_count = 0;

	always #2.5 ref_clk_in = ~ref_clk_in;

	// short carrier (64) and reconnect delay (16) keep the run brief
	pwo_gate_run #(.PWM_PERIOD_CYC(64), .RECONNECT_CYC(16)) dut (
		.ref_clk_in, .sys_rst_in, .duty_max_in, .duty_min_in, .chan_sel_in, .sense_sel_in,
		.auto_recover_in, .pf_use_in, .mod_type_in, .hw_run_en_in, .dead_time_ns_in, .ctrl_mode_in,
		.id_set_in, .iq_set_in, .pf_set_in, .vreg_out_in, .phase_ref_in, .cur_pos_in, .run_cmd_in,
		.fault_reset_cmd_in, .iso_run_in, .iso_fault_reset_in, .grid_v_in, .grid_v_min_in,
		.grid_v_max_in, .grid_freq_in, .grid_f_min_in, .grid_f_max_in, .other_fault_in,
		.gate_a_out, .gate_b_out, .state_out, .grid_v_fault_out, .grid_f_fault_out, .other_fault_out,
		.id_tgt_out, .iq_tgt_out, .grid_v_ln_out);

	pwo_gate_drv_model drv (.clk_in(ref_clk_in), .clr_in(clr), .gate_a_in(gate_a_out),
		.gate_b_in(gate_b_out), .top_cnt_out(top_cnt), .bot_cnt_out(bot_cnt), .shoot_cnt_out(shoot_cnt));

	// ********
	// access and compare tasks
	// ********
	task automatic step(input int n);
		repeat (n) @(posedge ref_clk_in);
		#1;
	endtask

	task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp)
		begin
			n_errors++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic chk_state(input logic [1:0] exp);
		chk_val(32'(state_out), 32'(exp));
	endtask

	task automatic refs(input logic [17:0] r0, input logic [17:0] r1, input logic [17:0] r2);
		phase_ref_in = {r2, r1, r0};
	endtask

	// channel a high-cycle count over one whole carrier period, per phase
	task automatic measure(input logic [7:0] e0, input logic [7:0] e1, input logic [7:0] e2, input logic on);
		logic [7:0] e [3];
		e = '{e0, e1, e2};
		step(140);
		clr = 1'b1;
		step(1);
		clr = 1'b0;
		step(64);
		for (int p = 0; p < 3; p++)
		begin
			chk_val(32'(top_cnt[p]), 32'(e[p]));
			chk_val(32'(bot_cnt[p]), 32'(on ? 8'h40 - e[p] : 8'h00));
		end
		chk_val(32'(shoot_cnt), 32'h0);
	endtask

	task automatic pulse_reset;
		fault_reset_cmd_in = 1'b1;
		step(1);
		fault_reset_cmd_in = 1'b0;
	endtask

	task automatic end_sim;
		$display("errors %0d checks %0d", n_errors, check_count);
		if (n_errors == 0 && check_count > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	initial
	begin
		#100000;
		n_errors++;
		end_sim;
	end

	initial
	begin
		step(6);
		sys_rst_in = 1'b0;
		step(4);
		measure(8'h00, 8'h00, 8'h00, 1'b0);
		run_cmd_in = 1'b1;
		refs(18'h08000, 18'h00000, 18'h38000);
		step(2);
		chk_state(2'h1);
		measure(8'h30, 8'h20, 8'h10, 1'b1);
		duty_max_in = 18'h08000;
		duty_min_in = 18'h38000;
		refs(18'h0e666, 18'h00000, 18'h30000);
		measure(8'h30, 8'h20, 8'h10, 1'b1);
		duty_max_in = 18'h0f333;
		duty_min_in = 18'h30ccd;
		chan_sel_in = 1'b1;
		refs(18'h08000, 18'h00000, 18'h38000);
		measure(8'h10, 8'h20, 8'h30, 1'b1);
		chan_sel_in = 1'b0;
		mod_type_in = 1'b0;
		refs(18'h08000, 18'h08000, 18'h08000);
		measure(8'h20, 8'h20, 8'h20, 1'b1);
		mod_type_in = 1'b1;
		measure(8'h30, 8'h30, 8'h30, 1'b1);
		dead_time_ns_in = 16'h0064;
		cur_pos_in = 3'h5;
		refs(18'h00000, 18'h00000, 18'h00000);
		measure(8'h34, 8'h0c, 8'h34, 1'b1);
		dead_time_ns_in = 16'h0000;
		measure(8'h20, 8'h20, 8'h20, 1'b1);
		chk_val(32'(id_tgt_out), 32'h4000);
		chk_val(32'(iq_tgt_out), 32'h2000);
		pf_use_in = 1'b1;
		step(2);
		chk_val(32'(iq_tgt_out), 32'h0);
		ctrl_mode_in = 1'b1;
		pf_use_in = 1'b0;
		step(2);
		chk_val(32'(id_tgt_out), 32'h3000);
		chk_val(32'(iq_tgt_out), 32'h0);
		ctrl_mode_in = 1'b0;
		chk_val(32'(grid_v_ln_out), 32'h5000);
		// above the window as a phase value, inside it once scaled from line-to-line
		grid_v_in = 16'he000;
		sense_sel_in = 1'b1;
		step(10);
		chk_state(2'h1);
		sense_sel_in = 1'b0;
		step(4);
		chk_state(2'h2);
		chk_val(32'(grid_v_fault_out), 32'h1);
		measure(8'h00, 8'h00, 8'h00, 1'b0);
		sense_sel_in = 1'b1;
		step(40);
		chk_state(2'h2);
		pulse_reset;
		step(6);
		chk_state(2'h1);
		auto_recover_in = 1'b1;
		grid_freq_in = 16'h0300;
		step(4);
		chk_state(2'h2);
		chk_val(32'(grid_f_fault_out), 32'h1);
		grid_freq_in = 16'h0100;
		step(6);
		chk_state(2'h2);
		step(30);
		chk_state(2'h1);
		chk_val(32'(grid_f_fault_out), 32'h0);
		auto_recover_in = 1'b0;
		hw_run_en_in = 1'b1;
		step(5);
		chk_state(2'h0);
		iso_run_in = 1'b1;
		step(5);
		chk_state(2'h1);
		run_cmd_in = 1'b0;
		step(5);
		chk_state(2'h1);
		other_fault_in = 1'b1;
		step(1);
		other_fault_in = 1'b0;
		step(3);
		chk_state(2'h2);
		chk_val(32'(other_fault_out), 32'h1);
		iso_fault_reset_in = 1'b1;
		step(8);
		chk_state(2'h1);
		chk_val(32'(other_fault_out), 32'h0);
		iso_run_in = 1'b0;
		step(5);
		chk_state(2'h0);
		hw_run_en_in = 1'b0;
		iso_run_in = 1'b1;
		step(5);
		chk_state(2'h0);
		run_cmd_in = 1'b1;
		other_fault_in = 1'b1;
		step(3);
		other_fault_in = 1'b0;
		chk_state(2'h2);
		iso_fault_reset_in = 1'b0;
		step(5);
		iso_fault_reset_in = 1'b1;
		step(8);
		chk_state(2'h2);
		pulse_reset;
		step(6);
		iso_run_in = 1'b0;
		step(5);
		chk_state(2'h1);
		end_sim;
	end
endmodule
